// ==== design/fmc_config_regs.sv ====
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module fmc_config_regs (
    input  wire logic                        mclk_i,
    input  wire logic                        rst_i,
    input  wire logic [7:0]                  addr_i,
    input  wire logic [15:0]                 wdata_i,
    input  wire logic                        wr_i,
    input  wire logic                        rd_i,
    input  wire logic                        io_supply_i,
    input  wire logic [9:0]                  tuned_station_index_i,
    input  wire fmc_pkg::fmc_measure_type    measure_i,
    input  wire logic                        measure_valid_i,
    output logic [15:0]                      rdata_o,
    output fmc_pkg::fmc_seek_cfg_type        seek_cfg_o,
    output fmc_pkg::fmc_audio_cfg_type       audio_cfg_o,
    output logic [15:0]                      tuned_freq_o,
    output logic                             channel_valid_o,
    output logic                             channel_valid_stb_o,
    output logic                             audio_highz_enable_o,
    output logic                             left_audio_out_bias_o,
    output logic                             right_audio_out_bias_o
);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [15:0] seek_band_volume_config;
    logic [15:0] softmute_seek_quality_config;
    logic [15:0] audio_output_test_word;
    logic [15:0] reserved_test_word;
    logic        power_up;
    logic        power_busy;
    logic [1:0]  io_supply_meta;
    logic        io_supply_sync;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire logic wr_sbv  = wr_i && hit(addr_i, fmc_pkg::ADDR_SEEK_BAND_VOLUME);
    wire logic wr_ssq  = wr_i && hit(addr_i, fmc_pkg::ADDR_SOFTMUTE_SEEK_QUALITY);
    wire logic wr_aot  = wr_i && hit(addr_i, fmc_pkg::ADDR_AUDIO_OUTPUT_TEST);
    wire logic wr_rtw  = wr_i && hit(addr_i, fmc_pkg::ADDR_RESERVED_TEST);
    wire logic wr_pwr  = wr_i && hit(addr_i, fmc_pkg::ADDR_POWER_CONTROL);
    wire logic wr_op   = wr_i && hit(addr_i, fmc_pkg::ADDR_OPERATION_CONTROL);
    wire logic op_start = wr_op && wdata_i[fmc_pkg::START_BIT];

    // powerup is in progress for one cycle after power_up rises; test-word writes
    // then are a software fault and are simply stored
    wire logic [15:0] power_word = {14'h0000, power_busy, power_up};

    logic [15:0] next_rdata;
    always_comb begin
        next_rdata = fmc_pkg::READ_UNMAPPED;
        unique case (addr_i)
            fmc_pkg::ADDR_SEEK_BAND_VOLUME:      next_rdata = seek_band_volume_config;
            fmc_pkg::ADDR_SOFTMUTE_SEEK_QUALITY: next_rdata = softmute_seek_quality_config;
            fmc_pkg::ADDR_AUDIO_OUTPUT_TEST:     next_rdata = audio_output_test_word;
            fmc_pkg::ADDR_RESERVED_TEST:         next_rdata = reserved_test_word;
            fmc_pkg::ADDR_POWER_CONTROL:         next_rdata = power_word;
            default:                             next_rdata = fmc_pkg::READ_UNMAPPED;
        endcase
    end

    // ----------------------------------------------------------------
    // field decode
    // ----------------------------------------------------------------
    wire logic [7:0] f_thr  = seek_band_volume_config[fmc_pkg::SEEK_TH_LSB +: 8];
    wire logic [1:0] f_band = seek_band_volume_config[fmc_pkg::BAND_LSB +: 2];
    wire logic [1:0] f_spc  = seek_band_volume_config[fmc_pkg::SPACE_LSB +: 2];
    wire logic [3:0] f_vol  = seek_band_volume_config[fmc_pkg::VOLUME_LSB +: 4];
    wire logic [1:0] f_rate = softmute_seek_quality_config[fmc_pkg::SM_RATE_LSB +: 2];
    wire logic [1:0] f_dep  = softmute_seek_quality_config[fmc_pkg::SM_DEPTH_LSB +: 2];
    wire logic [3:0] f_snr  = softmute_seek_quality_config[fmc_pkg::SNR_LSB +: 4];
    wire logic [3:0] f_imp  = softmute_seek_quality_config[fmc_pkg::IMPULSE_LSB +: 4];

    // depth code to attenuation in dB
    wire logic [4:0] depth_db = (f_dep == 2'h0) ? fmc_pkg::DEPTH_16_DB :
                                (f_dep == 2'h1) ? fmc_pkg::DEPTH_14_DB :
                                (f_dep == 2'h2) ? fmc_pkg::DEPTH_12_DB :
                                                  fmc_pkg::DEPTH_10_DB;

    // volume and rate pass straight through, depth is mapped to depth_db; the log volume curve lives in the dac path
    wire fmc_pkg::fmc_audio_cfg_type next_audio = '{volume: f_vol,
                                                     softmute_rate: f_rate,
                                                     softmute_depth_db: depth_db};

    // ----------------------------------------------------------------
    // frequency from latched band and spacing
    // ----------------------------------------------------------------
    wire logic [4:0] step = (seek_cfg_o.spacing == fmc_pkg::SPACE_100K) ? fmc_pkg::STEP_100K :
                            (seek_cfg_o.spacing == fmc_pkg::SPACE_50K)  ? fmc_pkg::STEP_50K :
                                                                          fmc_pkg::STEP_200K;
    wire logic [15:0] base = (seek_cfg_o.band == fmc_pkg::BAND_WIDE_EU) ?
                             fmc_pkg::BASE_875_MHZ : fmc_pkg::BASE_76_MHZ;
    wire logic [14:0] offs = tuned_station_index_i * step;
    wire logic [15:0] next_freq = base + {1'b0, offs};

    // ----------------------------------------------------------------
    // seek qualification on latched settings
    // ----------------------------------------------------------------
    wire logic strong_ok = measure_i.strength >= seek_cfg_o.seek_strength_threshold;
    wire logic snr_ok    = (seek_cfg_o.seek_snr_min == fmc_pkg::CHECK_OFF) ||
                           (measure_i.snr >= seek_cfg_o.seek_snr_min);
    // a larger code allows fewer impulses: allowed count is 15 minus code
    wire logic [3:0] imp_allow = 4'hF - seek_cfg_o.seek_impulse_limit;
    wire logic imp_ok    = (seek_cfg_o.seek_impulse_limit == fmc_pkg::CHECK_OFF) ||
                           (measure_i.impulses <= imp_allow);
    wire logic next_valid = strong_ok && snr_ok && imp_ok;

    // bias on the outputs only when powered down with io supply present
    wire logic next_bias = audio_output_test_word[fmc_pkg::HIGHZ_BIT] &&
                           !power_up && io_supply_sync;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        io_supply_meta <= {io_supply_meta[0], io_supply_i};
    end
    assign io_supply_sync = io_supply_meta[1];

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            seek_band_volume_config      <= fmc_pkg::RST_SEEK_BAND_VOLUME;
            softmute_seek_quality_config <= fmc_pkg::RST_SOFTMUTE_SEEK_QUALITY;
            audio_output_test_word       <= fmc_pkg::RST_AUDIO_OUTPUT_TEST;
            reserved_test_word           <= fmc_pkg::RST_RESERVED_TEST;
            power_up                     <= 1'b0;
            power_busy                   <= 1'b0;
        end else begin
            if (wr_sbv) seek_band_volume_config <= wdata_i;
            // reserved bits are stored as written; software keeps them zero
            if (wr_ssq) softmute_seek_quality_config <= wdata_i;
            if (wr_aot) audio_output_test_word <= wdata_i;
            if (wr_rtw) reserved_test_word <= wdata_i;
            if (wr_pwr) power_up <= wdata_i[fmc_pkg::PWR_UP_BIT];
            power_busy <= wr_pwr && wdata_i[fmc_pkg::PWR_UP_BIT] && !power_up;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rdata_o                <= 16'h0000;
            seek_cfg_o             <= '0;
            audio_cfg_o            <= '{volume: fmc_pkg::VOLUME_MUTE, softmute_rate: 2'h0,
                                        softmute_depth_db: fmc_pkg::DEPTH_16_DB};
            tuned_freq_o           <= fmc_pkg::BASE_875_MHZ;
            channel_valid_o        <= 1'b0;
            channel_valid_stb_o    <= 1'b0;
            audio_highz_enable_o   <= 1'b0;
            left_audio_out_bias_o  <= 1'b0;
            right_audio_out_bias_o <= 1'b0;
        end else begin
            rdata_o <= rd_i ? next_rdata : 16'h0000;
            if (op_start) begin
                seek_cfg_o <= '{seek_strength_threshold: f_thr, band: f_band,
                                spacing: f_spc, seek_snr_min: f_snr,
                                seek_impulse_limit: f_imp};
            end
            audio_cfg_o            <= next_audio;
            tuned_freq_o           <= next_freq;
            if (measure_valid_i) channel_valid_o <= next_valid;
            channel_valid_stb_o    <= measure_valid_i;
            audio_highz_enable_o   <= audio_output_test_word[fmc_pkg::HIGHZ_BIT];
            left_audio_out_bias_o  <= next_bias;
            right_audio_out_bias_o <= next_bias;
        end
    end

endmodule

// ==== design/fmc_pkg.sv ====
package fmc_pkg;

    // ----------------------------------------------------------------
    // register word addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_SEEK_BAND_VOLUME      = 8'h05;
    localparam logic [7:0] ADDR_SOFTMUTE_SEEK_QUALITY = 8'h06;
    localparam logic [7:0] ADDR_AUDIO_OUTPUT_TEST     = 8'h07;
    localparam logic [7:0] ADDR_RESERVED_TEST         = 8'h08;
    localparam logic [7:0] ADDR_POWER_CONTROL         = 8'h10;
    localparam logic [7:0] ADDR_OPERATION_CONTROL     = 8'h11;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_SEEK_BAND_VOLUME      = 16'h0000;
    localparam logic [15:0] RST_SOFTMUTE_SEEK_QUALITY = 16'h0000;
    localparam logic [15:0] RST_AUDIO_OUTPUT_TEST     = 16'h0100;
    localparam logic [15:0] RST_RESERVED_TEST         = 16'h0000;
    localparam logic [15:0] READ_UNMAPPED             = 16'h0000;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int SEEK_TH_LSB     = 8;
    localparam int BAND_LSB        = 6;
    localparam int SPACE_LSB       = 4;
    localparam int VOLUME_LSB      = 0;
    localparam int SM_RATE_LSB     = 14;
    localparam int SM_DEPTH_LSB    = 12;
    localparam int SNR_LSB         = 4;
    localparam int IMPULSE_LSB     = 0;
    localparam int HIGHZ_BIT       = 14;
    localparam int PWR_UP_BIT      = 0;
    localparam int PWR_BUSY_BIT    = 1;
    localparam int START_BIT       = 0;

    // ----------------------------------------------------------------
    // field encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] BAND_WIDE_EU = 2'h0;
    localparam logic [1:0] BAND_RESVD   = 2'h3;
    localparam logic [1:0] SPACE_200K   = 2'h0;
    localparam logic [1:0] SPACE_100K   = 2'h1;
    localparam logic [1:0] SPACE_50K    = 2'h2;
    localparam logic [3:0] CHECK_OFF    = 4'h0;
    localparam logic [3:0] VOLUME_MUTE  = 4'h0;

    // frequencies in 10 kHz units
    localparam logic [15:0] BASE_875_MHZ = 16'h222E;
    localparam logic [15:0] BASE_76_MHZ  = 16'h1DB0;
    localparam logic [4:0]  STEP_200K    = 5'h14;
    localparam logic [4:0]  STEP_100K    = 5'h0A;
    localparam logic [4:0]  STEP_50K     = 5'h05;

    // softmute depth in dB
    localparam logic [4:0] DEPTH_16_DB = 5'h10;
    localparam logic [4:0] DEPTH_14_DB = 5'h0E;
    localparam logic [4:0] DEPTH_12_DB = 5'h0C;
    localparam logic [4:0] DEPTH_10_DB = 5'h0A;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  seek_strength_threshold;
        logic [1:0]  band;
        logic [1:0]  spacing;
        logic [3:0]  seek_snr_min;
        logic [3:0]  seek_impulse_limit;
    } fmc_seek_cfg_type;

    typedef struct packed {
        logic [3:0]  volume;
        logic [1:0]  softmute_rate;
        logic [4:0]  softmute_depth_db;
    } fmc_audio_cfg_type;

    typedef struct packed {
        logic [7:0]  strength;
        logic [3:0]  snr;
        logic [3:0]  impulses;
    } fmc_measure_type;

endpackage

// ==== tb/fmc_config_regs_monitor.sv ====
`timescale 1ns/1ps
module fmc_config_regs_monitor (
    input wire logic                       mclk_i,
    input wire logic                       rst_i,
    input wire logic [7:0]                 addr_i,
    input wire logic [15:0]                wdata_i,
    input wire logic                       wr_i,
    input wire logic                       rd_i,
    input wire logic                       io_supply_i,
    input wire logic [9:0]                 tuned_station_index_i,
    input wire fmc_pkg::fmc_measure_type   measure_i,
    input wire logic                       measure_valid_i,
    input wire logic [15:0]                rdata_o,
    input wire fmc_pkg::fmc_seek_cfg_type  seek_cfg_o,
    input wire fmc_pkg::fmc_audio_cfg_type audio_cfg_o,
    input wire logic [15:0]                tuned_freq_o,
    input wire logic                       channel_valid_o,
    input wire logic                       channel_valid_stb_o,
    input wire logic                       audio_highz_enable_o,
    input wire logic                       left_audio_out_bias_o,
    input wire logic                       right_audio_out_bias_o
);
    // ----
    // shadow of the second test word, so a read can be judged whatever came before
    // ----
    logic [15:0] shadow;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            shadow <= 16'h0000;
        end else if (wr_i && addr_i == fmc_pkg::ADDR_RESERVED_TEST) begin
            shadow <= wdata_i;
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // ----
    // checks
    // ----
    rd_window_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data outside the read cycle");
    test_back_a: assert property (
        rd_i && addr_i == fmc_pkg::ADDR_RESERVED_TEST |=> rdata_o == shadow)
        else $error("second test word read back wrong");
    stb_a: assert property (measure_valid_i |=> channel_valid_stb_o)
        else $error("no strobe after a measurement");
    strength_a: assert property (
        measure_valid_i && measure_i.strength < seek_cfg_o.seek_strength_threshold
        |=> !channel_valid_o) else $error("weak channel accepted");
    snr_a: assert property (measure_valid_i && seek_cfg_o.seek_snr_min != 4'h0 &&
        measure_i.snr < seek_cfg_o.seek_snr_min |=> !channel_valid_o)
        else $error("low snr channel accepted");
    impulse_a: assert property (
        measure_valid_i && seek_cfg_o.seek_impulse_limit != 4'h0 &&
        measure_i.impulses > 4'hF - seek_cfg_o.seek_impulse_limit |=> !channel_valid_o)
        else $error("noisy channel accepted");
    volume_a: assert property (
        wr_i && addr_i == fmc_pkg::ADDR_SEEK_BAND_VOLUME
        |=> ##1 audio_cfg_o.volume == $past(wdata_i[3:0], 2)) else $error("volume wrong");
    depth_a: assert property (
        wr_i && addr_i == fmc_pkg::ADDR_SOFTMUTE_SEEK_QUALITY
        |=> ##1 audio_cfg_o.softmute_depth_db == 5'h10 - {2'h0, $past(wdata_i[13:12], 2), 1'b0})
        else $error("softmute depth wrong");
    highz_off_a: assert property (
        !audio_highz_enable_o [*2] |-> !left_audio_out_bias_o && !right_audio_out_bias_o)
        else $error("bias without high-z enable");
    supply_off_a: assert property (!io_supply_i [*4] |-> !left_audio_out_bias_o)
        else $error("bias without io supply");
endmodule
bind fmc_config_regs fmc_config_regs_monitor i_mon (.mclk_i, .rst_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .io_supply_i, .tuned_station_index_i, .measure_i, .measure_valid_i,
    .rdata_o, .seek_cfg_o, .audio_cfg_o, .tuned_freq_o, .channel_valid_o, .channel_valid_stb_o,
    .audio_highz_enable_o, .left_audio_out_bias_o, .right_audio_out_bias_o);

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    logic                       mclk_i = 1'b0;
    logic                       rst_i = 1'b1;
    logic [7:0]                 addr_i = 8'h00;
    logic [15:0]                wdata_i = 16'h0000;
    logic                       wr_i = 1'b0;
    logic                       rd_i = 1'b0;
    logic                       io_supply_i = 1'b1;
    logic [9:0]                 idx = 10'h064;
    fmc_pkg::fmc_measure_type   meas = '0;
    logic                       meas_vld = 1'b0;
    logic [15:0]                rdata_o, tuned_freq_o;
    fmc_pkg::fmc_seek_cfg_type  seek_cfg_o;
    fmc_pkg::fmc_audio_cfg_type audio_cfg_o;
    logic                       vld_o, stb_o, hz_o, lb_o, rb_o;
    int                         error_cnt = 0;
    int                         n_checks = 0;
    fmc_config_regs i_dut (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .io_supply_i,
        .tuned_station_index_i(idx), .measure_i(meas), .measure_valid_i(meas_vld), .rdata_o,
        .seek_cfg_o, .audio_cfg_o, .tuned_freq_o, .channel_valid_o(vld_o),
        .channel_valid_stb_o(stb_o), .audio_highz_enable_o(hz_o),
        .left_audio_out_bias_o(lb_o), .right_audio_out_bias_o(rb_o));
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    // ----
    // bus and compare helpers; one idle cycle between strobes keeps drivers race free
    // ----
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 cmp(rdata_o, exp, what);
    endtask
    task automatic meas_chk(input logic [15:0] m, input logic e);
        @(posedge mclk_i);
        meas <= m;
        meas_vld <= 1'b1;
        @(posedge mclk_i);
        meas_vld <= 1'b0;
        #1 cmp({15'h0000, vld_o}, {15'h0000, e}, "channel valid");
        cmp({15'h0000, stb_o}, 16'h0001, "valid strobe");
    endtask
    task automatic wait_bias(input logic e);
        int n;
        for (n = 0; n < 8 && lb_o !== e; n++) begin
            @(posedge mclk_i);
            #1;
        end
        cmp({14'h0000, lb_o, rb_o}, {14'h0000, e, e}, "audio bias");
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_reset_rw;
        rd(8'h05, 16'h0000, "reg05 reset");
        rd(8'h06, 16'h0000, "reg06 reset");
        rd(8'h07, 16'h0100, "reg07 reset");
        rd(8'h08, 16'h0000, "reg08 reset");
        rd(8'h3F, 16'h0000, "unmapped read");
        wr(8'h08, 16'hA5C3);
        rd(8'h08, 16'hA5C3, "reg08 back");
    endtask
    task automatic t_audio;
        logic [3:0] vol [4] = '{4'h0, 4'h1, 4'hE, 4'hF};
        for (int c = 0; c < 4; c++) begin
            wr(8'h06, {c[1:0], c[1:0], 12'h000});
            wr(8'h05, {12'h000, vol[c]});
            @(posedge mclk_i);
            #1 cmp({11'h000, audio_cfg_o.softmute_depth_db}, 16'(16 - 2 * c), "depth");
            cmp({14'h0000, audio_cfg_o.softmute_rate}, 16'(c), "rate");
            cmp({12'h000, audio_cfg_o.volume}, {12'h000, vol[c]}, "volume");
        end
    endtask
    task automatic t_freq;
        logic [15:0] base, step;
        logic [3:0]  last = 4'h0;
        for (int b = 0; b < 3; b++) begin
            for (int s = 0; s < 3; s++) begin
                base = (b == 0) ? 16'h222E : 16'h1DB0;
                step = (s == 0) ? 16'h0014 : (s == 1) ? 16'h000A : 16'h0005;
                wr(8'h05, {8'h00, b[1:0], s[1:0], 4'h0});
                #1 cmp({12'h000, seek_cfg_o.band, seek_cfg_o.spacing}, {12'h000, last}, "held");
                wr(8'h11, 16'h0001);
                repeat (3) @(posedge mclk_i);
                #1 cmp({12'h000, seek_cfg_o.band, seek_cfg_o.spacing}, {12'h000, b[1:0], s[1:0]}, "band");
                cmp(tuned_freq_o, base + 16'(idx) * step, "tuned frequency");
                last = {b[1:0], s[1:0]};
            end
        end
    endtask
    task automatic t_meas;
        logic [15:0] m [5] = '{16'h404C, 16'h3FF0, 16'hFF30, 16'hFFFD, 16'hFF4C};
        logic [4:0]  e = 5'h11;
        wr(8'h05, 16'h4000);
        wr(8'h06, 16'h0043);
        wr(8'h11, 16'h0001);
        for (int i = 0; i < 5; i++) begin
            meas_chk(m[i], e[i]);
        end
        wr(8'h06, 16'h0000);
        wr(8'h11, 16'h0001);
        meas_chk(16'hFF0F, 1'b1);
    endtask
    task automatic t_highz;
        wr(8'h07, 16'h4100);
        wait_bias(1'b1);
        cmp({15'h0000, hz_o}, 16'h0001, "high-z flag set");
        io_supply_i <= 1'b0;
        wait_bias(1'b0);
        io_supply_i <= 1'b1;
        wait_bias(1'b1);
        wr(8'h10, 16'h0001);
        wait_bias(1'b0);
        repeat (4) @(posedge mclk_i);
        wr(8'h07, 16'h3C04);
        rd(8'h07, 16'h3C04, "reg07 powered up");
        cmp({15'h0000, hz_o}, 16'h0000, "high-z flag");
    endtask
    initial begin
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_reset_rw();
        t_audio();
        t_freq();
        t_meas();
        t_highz();
        give_verdict();
    end
endmodule
